// ===== core/fes_defines.vh
// constants for the flash erase/suspend host sequencer
`ifndef FES_DEFINES_VH
`define FES_DEFINES_VH
// unlock addresses and data (word mode)
`define FES_UNLOCK1_ADDR   22'h000555
`define FES_UNLOCK2_ADDR   22'h0002AA
`define FES_UNLOCK1_DATA   16'h00AA
`define FES_UNLOCK2_DATA   16'h0055
`define FES_ERASE_SETUP    16'h0080
`define FES_SECTOR_ERASE   16'h0030
`define FES_CHIP_ERASE     16'h0010
`define FES_ERASE_SUSPEND  16'h00B0
`define FES_ERASE_RESUME   16'h0030
`define FES_PROG_SUSPEND   16'h0051
`define FES_PROG_RESUME    16'h0050
`define FES_RESET_CMD      16'h00F0
`define FES_POLL_BIT       7
// bus cycle timing: clock period and strobe low width in ns, strobe width in clock cycles
`define FES_CLK_NS         8
`define FES_STROBE_NS      70
`define FES_STROBE_CYC     ((`FES_STROBE_NS + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_SEQ_LEN        3'd6
`define FES_RESET_LEN      3'd3
`endif

// ===== core/fes_host.v
// host sequencer: issues erase/suspend/resume commands and polls the flash
// Notes on behaviour
// - sector erase is six writes: two unlocks, setup, two unlocks, erase at sector.
// - one sector per erase; wait for completion before the next.
// - chip erase ignores commands; hardware reset aborts; reissue later.
// - erase resume goes to suspended sector; repeats ignored; re-suspend allowed.
// - program resume with any address; repeats ignored; re-suspend allowed.
// - unlock sectors before high voltage; use it only for acceleration.
// - buffered program status valid only at last loaded word.
`include "fes_defines.vh"
module fes_host (
   input  wire        clock,
   input  wire        reset,
   // user side
   input  wire        cmd_valid,
   input  wire [2:0]  cmd_op,
   input  wire [21:0] cmd_addr,
   input  wire [7:0]  cmd_poll_data,
   output wire        cmd_ready,
   output reg         done_q,
   output reg         busy_q,
   output reg         suspended_q,
   output reg  [15:0] rdata_q,
   input  wire        accel_req,
   // flash pins
   output reg  [21:0] flash_addr_q,
   output reg  [15:0] flash_dq_out_q,
   output reg         flash_dq_oe_q,
   input  wire [15:0] flash_dq_in,
   output reg         flash_ce_n_q,
   output reg         flash_we_n_q,
   output reg         flash_oe_n_q,
   output reg         protect_accel_pin
);
   // user operations
   localparam OP_SECTOR = 3'd0, OP_CHIP = 3'd1, OP_ESUSP = 3'd2, OP_ERES = 3'd3;
   localparam OP_PSUSP = 3'd4, OP_PRES = 3'd5, OP_RESET = 3'd6, OP_READ = 3'd7;
   // one-hot states
   localparam S_IDLE = 6'h01, S_WR = 6'h02, S_RD = 6'h04, S_POLL = 6'h08;
   localparam S_GAP = 6'h10, S_DONE = 6'h20;

   reg [5:0]  st_q;
   reg [2:0]  op_q;
   reg [2:0]  idx_q;
   reg [2:0]  len_q;
   reg [7:0]  cnt_q;
   reg [21:0] tgt_q;
   reg [7:0]  pd_q;
   reg [15:0] din_s1_q;
   reg [15:0] din_s2_q;
   reg        acc_s1_q;
   reg        acc_s2_q;
   reg        erasing_q;
   reg        chip_q;
   reg [21:0] wa;
   reg [15:0] wd;
   wire       susp_take;

   // suspend breaks polling: only an erase suspend may enter a running sector erase
   assign susp_take = st_q[3] & erasing_q & ~chip_q & ~suspended_q & ~din_s2_q[`FES_POLL_BIT]
                      & cmd_valid & (cmd_op == OP_ESUSP);
   assign cmd_ready = st_q[0] | susp_take;

   // data bus and accel request pass two flops before use
   always @(posedge clock) begin
      if (reset) begin
         din_s1_q <= 16'h0000;
         din_s2_q <= 16'h0000;
         acc_s1_q <= 1'b0;
         acc_s2_q <= 1'b0;
      end else begin
         din_s1_q <= flash_dq_in;
         din_s2_q <= din_s1_q;
         acc_s1_q <= accel_req;
         acc_s2_q <= acc_s1_q;
      end
   end

   // address/data of write step idx for the current operation
   always @* begin
      wa = `FES_UNLOCK1_ADDR;
      wd = `FES_UNLOCK1_DATA;
      case (op_q)
         OP_SECTOR, OP_CHIP: begin
            case (idx_q)
               3'd0, 3'd3: begin wa = `FES_UNLOCK1_ADDR; wd = `FES_UNLOCK1_DATA; end
               3'd1, 3'd4: begin wa = `FES_UNLOCK2_ADDR; wd = `FES_UNLOCK2_DATA; end
               3'd2: begin wa = `FES_UNLOCK1_ADDR; wd = `FES_ERASE_SETUP; end
               default: begin
                  wa = (op_q == OP_CHIP) ? `FES_UNLOCK1_ADDR : tgt_q;
                  wd = (op_q == OP_CHIP) ? `FES_CHIP_ERASE : `FES_SECTOR_ERASE;
               end
            endcase
         end
         OP_ESUSP: begin wa = tgt_q; wd = `FES_ERASE_SUSPEND; end
         OP_ERES:  begin wa = tgt_q; wd = `FES_ERASE_RESUME; end
         OP_PSUSP: begin wa = tgt_q; wd = `FES_PROG_SUSPEND; end
         OP_PRES:  begin wa = tgt_q; wd = `FES_PROG_RESUME; end
         OP_RESET: begin
            case (idx_q)
               3'd0: begin wa = `FES_UNLOCK1_ADDR; wd = `FES_UNLOCK1_DATA; end
               3'd1: begin wa = `FES_UNLOCK2_ADDR; wd = `FES_UNLOCK2_DATA; end
               default: begin wa = `FES_UNLOCK1_ADDR; wd = `FES_RESET_CMD; end
            endcase
         end
         default: begin wa = tgt_q; wd = 16'h0000; end
      endcase
   end

   // main sequencer: write cycles, then polling reads
   always @(posedge clock) begin
      if (reset) begin
         // reset drops erase; the user reissues it once array read is back
         st_q <= S_IDLE;
         op_q <= OP_READ;
         idx_q <= 3'd0;
         len_q <= 3'd1;
         cnt_q <= 8'h00;
         tgt_q <= 22'h000000;
         pd_q <= 8'h00;
         erasing_q <= 1'b0;
         chip_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
         suspended_q <= 1'b0;
         rdata_q <= 16'h0000;
         flash_addr_q <= 22'h000000;
         flash_dq_out_q <= 16'h0000;
         flash_dq_oe_q <= 1'b0;
         flash_ce_n_q <= 1'b1;
         flash_we_n_q <= 1'b1;
         flash_oe_n_q <= 1'b1;
         protect_accel_pin <= 1'b0;
      end else begin
         done_q <= 1'b0;
         // accel voltage on request, only when not erasing
         protect_accel_pin <= acc_s2_q & ~erasing_q;
         case (st_q)
            S_IDLE: begin
               if (cmd_valid) begin
                  op_q <= cmd_op;
                  tgt_q <= cmd_addr;
                  pd_q <= cmd_poll_data;
                  idx_q <= 3'd0;
                  cnt_q <= 8'h00;
                  busy_q <= 1'b1;
                  case (cmd_op)
                     OP_SECTOR, OP_CHIP: len_q <= `FES_SEQ_LEN;
                     OP_RESET: len_q <= `FES_RESET_LEN;
                     default: len_q <= 3'd1;
                  endcase
                  st_q <= (cmd_op == OP_READ) ? S_RD : S_WR;
               end
            end
            S_WR: begin
               // strobe low for the strobe width, then rise to latch data
               flash_addr_q <= wa;
               flash_dq_out_q <= wd;
               flash_dq_oe_q <= 1'b1;
               flash_ce_n_q <= 1'b0;
               flash_oe_n_q <= 1'b1;
               if (cnt_q < `FES_STROBE_CYC) begin
                  flash_we_n_q <= 1'b0;
                  cnt_q <= cnt_q + 8'h01;
               end else begin
                  flash_we_n_q <= 1'b1;
                  cnt_q <= 8'h00;
                  st_q <= S_GAP;
               end
            end
            S_GAP: begin
               flash_ce_n_q <= 1'b1;
               flash_dq_oe_q <= 1'b0;
               if (idx_q + 3'd1 < len_q) begin
                  idx_q <= idx_q + 3'd1;
                  st_q <= S_WR;
               end else if (op_q == OP_SECTOR || op_q == OP_CHIP) begin
                  erasing_q <= 1'b1;
                  chip_q <= (op_q == OP_CHIP);
                  suspended_q <= 1'b0;
                  st_q <= S_RD;
               end else begin
                  // an erase suspend with no sector erase running leaves nothing suspended
                  if (op_q == OP_ESUSP) suspended_q <= erasing_q & ~chip_q;
                  if (op_q == OP_PSUSP) suspended_q <= ~chip_q;
                  if (op_q == OP_ERES || op_q == OP_PRES) suspended_q <= 1'b0;
                  if (op_q == OP_ERES) st_q <= S_RD;
                  else st_q <= S_DONE;
               end
            end
            S_RD: begin
               // read cycle with output enable held for the access time
               // status read only at the operation's own address
               flash_addr_q <= tgt_q;
               flash_ce_n_q <= 1'b0;
               flash_oe_n_q <= 1'b0;
               flash_dq_oe_q <= 1'b0;
               if (cnt_q < `FES_STROBE_CYC + 8'd2) cnt_q <= cnt_q + 8'h01;
               else begin
                  cnt_q <= 8'h00;
                  st_q <= S_POLL;
               end
            end
            S_POLL: begin
               flash_ce_n_q <= 1'b1;
               flash_oe_n_q <= 1'b1;
               rdata_q <= din_s2_q;
               if (susp_take) begin
                  // suspend taken between status reads; sector address is kept
                  op_q <= OP_ESUSP;
                  idx_q <= 3'd0;
                  len_q <= 3'd1;
                  cnt_q <= 8'h00;
                  st_q <= S_WR;
               end else if (op_q == OP_READ) st_q <= S_DONE;
               else if (din_s2_q[`FES_POLL_BIT]) begin
                  erasing_q <= 1'b0;
                  chip_q <= 1'b0;
                  op_q <= OP_READ;
                  st_q <= S_RD;
               end else st_q <= S_RD;
            end
            S_DONE: begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // fes_host

// ===== dv/fes_flash_model.sv
// behavioural flash device: erase, suspend and the poll bit
module fes_flash_model #(
   parameter int ERASE_NS = 3000
) (
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic [15:0] din,
   output wire logic [15:0] dout
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        erasing = 1'b0;
   logic        susp    = 1'b0;
   logic        chip    = 1'b0;
   logic [15:0] held    = 16'h0000;
   int          n_wr    = 0;
   int          left    = 0;
   wire  [15:0] val     = (erasing && !susp) ? 16'h0000 : 16'hFFFF;
   // program, query and protect writes are ignored
   always @(posedge we_n) begin
      if (!ce_n && erasing) begin
         if (!chip && din == 16'h00B0) susp = 1'b1;
         else if (susp && din == 16'h0030) susp = 1'b0;
      end else if (!ce_n) begin
         if (n_wr == 5 || din == 16'h00AA || din == 16'h0055 || din == 16'h0080) n_wr++;
         else n_wr = 0;
      end
      if (n_wr == 6) begin
         n_wr = 0;
         erasing = 1'b1;
         chip = (din == 16'h0010);
         left = ERASE_NS;
      end
   end
   // erase ends after its run time, frozen while suspended
   always begin
      #10;
      if (erasing && !susp) left -= 10;
      if (erasing && left <= 0) erasing = 1'b0;
   end
   // status while erasing; a released bus shows the inverse
   always @(posedge oe_n or posedge ce_n) held = ~val;
   assign dout = (oe_n || ce_n) ? held : val;
endmodule // fes_flash_model

// ===== dv/fes_host_sva.sv
// assertions on the flash host sequencer ports
module fes_host_sva (
   input wire        clock,
   input wire        reset,
   input wire        cmd_valid,
   input wire [2:0]  cmd_op,
   input wire        cmd_ready,
   input wire        done_q,
   input wire        busy_q,
   input wire [15:0] rdata_q,
   input wire [15:0] flash_dq_out_q,
   input wire        flash_dq_oe_q,
   input wire        flash_ce_n_q,
   input wire        flash_we_n_q,
   input wire        flash_oe_n_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic [2:0] op_q;
   logic [3:0] wr_q;
   wire  [3:0] exp_wr = op_q < 3'h2 ? 4'h6 : op_q == 3'h6 ? 4'h3 : op_q == 3'h7 ? 4'h0 : 4'h1;
   // count write strobes of the current operation
   always_ff @(posedge clock) begin
      if (reset) wr_q <= 4'h0;
      else if (cmd_valid && cmd_ready) wr_q <= 4'h0;
      else if ($rose(flash_we_n_q)) wr_q <= wr_q + 4'h1;
      if (cmd_valid && cmd_ready) op_q <= cmd_op;
   end
   sequence s_strobe;
      ##1 (!flash_we_n_q) [*8] ##1 flash_we_n_q;
   endsequence
   chk_we_width: assert property ($fell(flash_we_n_q) |-> s_strobe)
      else $error("write strobe width wrong");
   chk_write_mode: assert property (!flash_we_n_q |-> !flash_ce_n_q && flash_oe_n_q)
      else $error("write strobe outside a write cycle");
   chk_no_contend: assert property (!flash_oe_n_q |-> !flash_dq_oe_q)
      else $error("data driven during a read");
   chk_data_hold: assert property (!flash_we_n_q && !$fell(flash_we_n_q) |-> $stable(flash_dq_out_q))
      else $error("data moved under the strobe");
   chk_busy_refuse: assert property (busy_q && !(cmd_valid && cmd_op == 3'h2) |-> !cmd_ready)
      else $error("ready while busy");
   chk_susp_only: assert property (busy_q && cmd_ready |-> cmd_valid && cmd_op == 3'h2)
      else $error("non-suspend request taken while busy");
   chk_done_pulse: assert property (done_q |=> !done_q)
      else $error("done longer than one cycle");
   chk_write_count: assert property (done_q |-> wr_q == exp_wr)
      else $error("wrong number of writes");
   chk_erase_poll: assert property (done_q && (op_q < 3'h2 || op_q == 3'h3) |-> rdata_q[7])
      else $error("erase ended before poll bit high");
   chk_reset_idle: assert property (disable iff (1'b0) reset |=> flash_we_n_q && flash_ce_n_q)
      else $error("strobes active after reset");
endmodule // fes_host_sva
bind fes_host fes_host_sva u_sva (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
   .cmd_op(cmd_op), .cmd_ready(cmd_ready), .done_q(done_q), .busy_q(busy_q), .rdata_q(rdata_q),
   .flash_dq_out_q(flash_dq_out_q), .flash_dq_oe_q(flash_dq_oe_q), .flash_ce_n_q(flash_ce_n_q),
   .flash_we_n_q(flash_we_n_q), .flash_oe_n_q(flash_oe_n_q));

// ===== dv/tb_fes_host.sv
// self-checking bench: flash host sequencer against the flash model
module tb_fes_host;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        cmd_valid = 1'b0;
   logic        accel_req = 1'b0;
   logic [2:0]  cmd_op = 3'h0;
   logic [21:0] cmd_addr = 22'h000000;
   wire         cmd_ready, done_q, busy_q, suspended_q, dq_oe, ce_n, we_n, oe_n, pin;
   wire  [15:0] rdata_q, dq_out, dq_in;
   wire  [21:0] faddr;
   int          n_errors = 0;
   int          check_count = 0;
   fes_host dut (.clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_poll_data(8'h80), .cmd_ready(cmd_ready), .done_q(done_q),
      .busy_q(busy_q), .suspended_q(suspended_q), .rdata_q(rdata_q), .accel_req(accel_req),
      .flash_addr_q(faddr), .flash_dq_out_q(dq_out), .flash_dq_oe_q(dq_oe),
      .flash_dq_in(dq_in), .flash_ce_n_q(ce_n), .flash_we_n_q(we_n), .flash_oe_n_q(oe_n),
      .protect_accel_pin(pin));
   fes_flash_model #(.ERASE_NS(3000)) flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .din(dq_out), .dout(dq_in));
   initial forever #4 clock = ~clock;
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      if (n_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // hold a request from a rising edge until ready is seen, then release it at the take edge
   task automatic issue(input logic [2:0] op, input logic [21:0] a);
      int i;
      @(posedge clock);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_valid <= 1'b1;
      @(negedge clock);
      for (i = 0; i < 5000 && cmd_ready !== 1'b1; i++) @(negedge clock);
      if (i == 5000) begin
         n_errors++;
         results();
      end
      @(posedge clock);
      cmd_valid <= 1'b0;
      @(negedge clock);
      check("ready_busy", 16'(cmd_ready), 16'h0000);
   endtask
   // wait for the done pulse under a bound
   task automatic wait_done();
      int i;
      for (i = 0; i < 5000 && done_q !== 1'b1; i++) @(negedge clock);
      if (i == 5000) begin
         n_errors++;
         results();
      end
   endtask
   // one operation: request, then wait for done
   task automatic run(input logic [2:0] op, input logic [21:0] a);
      issue(op, a);
      wait_done();
   endtask
   task automatic t_erase();
      for (int k = 0; k < 2; k++) begin
         run(3'(k), 22'h010000);
         check("erase_data", rdata_q, 16'hFFFF);
         check("erase_susp", 16'(suspended_q), 16'h0000);
      end
   endtask
   // suspend a running sector erase, read the suspended sector, then resume to the end
   task automatic t_suspend();
      issue(3'h0, 22'h010000);
      run(3'h2, 22'h010000);
      check("susp_set", 16'(suspended_q), 16'h0001);
      run(3'h7, 22'h010000);
      check("susp_status", rdata_q, 16'hFFFF);
      run(3'h4, 22'h000000);
      run(3'h5, 22'h3FFFFF);
      run(3'h3, 22'h010000);
      check("susp_clear", 16'(suspended_q), 16'h0000);
      check("resume_data", rdata_q, 16'hFFFF);
   endtask
   task automatic t_misc();
      run(3'h6, 22'h000000);
      run(3'h7, 22'h000100);
      check("read_data", rdata_q, 16'hFFFF);
   endtask
   task automatic t_accel();
      int i;
      @(posedge clock);
      accel_req <= 1'b1;
      for (i = 0; i < 8 && pin !== 1'b1; i++) @(negedge clock);
      check("accel_on", 16'(pin), 16'h0001);
      @(posedge clock);
      accel_req <= 1'b0;
      for (i = 0; i < 8 && pin !== 1'b0; i++) @(negedge clock);
      check("accel_off", 16'(pin), 16'h0000);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      t_accel();
      t_erase();
      t_suspend();
      t_misc();
      results();
   end
endmodule // tb_fes_host
